// ### core/gtl_dev_port.sv
// instrument talker/listener end of the bus
`default_nettype none
module gtl_dev_port (
  input wire logic CLK,
  input wire logic RESETN,
  gtl_bus_if.dev BUS,
  input wire logic [gtl_pkg::AW-1:0] MY_ADDR,
  input wire logic SRQ_REQ,
  input wire logic TX_VALID,
  input wire logic [gtl_pkg::DW-1:0] TX_DATA,
  input wire logic TX_EOI,
  output logic TX_READY,
  output logic TX_DONE,
  input wire logic RX_READY,
  output logic RX_VALID,
  output logic [gtl_pkg::DW-1:0] RX_DATA,
  output logic RX_EOI,
  output logic TALK,
  output logic LISTEN,
  output logic REMOTE
);
  logic atn_on;
  logic ifc_on;
  logic ren_on;
  logic dav_on;
  logic talk_r;
  logic listen_r;
  logic remote_r;
  logic srq_r;
  gtl_pkg::gtl_acc_t acc_r;
  logic acc_en;
  logic acc_rdy;
  logic take;
  logic got_r;
  logic rx_atn_r;
  logic [gtl_pkg::DW-1:0] rx_data_r;
  logic rx_eoi_r;
  logic [gtl_pkg::DW-2:0] cmd;
  logic cmd_seen;
  logic [gtl_pkg::DW-1:0] src_dio;
  logic src_dav;
  logic src_eoi;
  logic src_en;
  logic [gtl_pkg::NLINES-1:0] drv;

  // management lines are negative true
  assign atn_on = ~BUS.line[gtl_pkg::L_ATN];
  assign ifc_on = ~BUS.line[gtl_pkg::L_IFC];
  assign ren_on = ~BUS.line[gtl_pkg::L_REN];
  assign dav_on = ~BUS.line[gtl_pkg::L_DAV];

  // acceptor: every device joins the handshake under ATN, data only when addressed
  assign acc_en = (atn_on || listen_r) && !ifc_on;
  assign acc_rdy = atn_on || RX_READY;
  assign take = acc_r == gtl_pkg::ACC_WAIT && acc_en && acc_rdy && dav_on;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      acc_r <= gtl_pkg::ACC_OFF;
    else if (!acc_en)
      acc_r <= gtl_pkg::ACC_OFF;
    else
      unique case (acc_r)
        gtl_pkg::ACC_OFF:
          acc_r <= gtl_pkg::ACC_WAIT;
        gtl_pkg::ACC_WAIT:
          if (take)
            acc_r <= gtl_pkg::ACC_TAKEN;
        gtl_pkg::ACC_TAKEN:
          if (!dav_on)
            acc_r <= gtl_pkg::ACC_WAIT;
        default:
          acc_r <= gtl_pkg::ACC_OFF;
      endcase
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rx_data_r <= '0;
      rx_eoi_r <= 1'b0;
      rx_atn_r <= 1'b0;
    end
    else if (take)
    begin
      rx_data_r <= ~BUS.line[gtl_pkg::DW-1:0];
      rx_eoi_r <= ~BUS.line[gtl_pkg::L_EOI];
      rx_atn_r <= atn_on;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      got_r <= 1'b0;
    else
      got_r <= take;
  end

  assign cmd = rx_data_r[gtl_pkg::DW-2:0];
  assign cmd_seen = got_r && rx_atn_r;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      listen_r <= 1'b0;
    else if (ifc_on)
      listen_r <= 1'b0;
    else if (cmd_seen && cmd == {gtl_pkg::GRP_LISTEN, MY_ADDR})
      listen_r <= 1'b1;
    else if (cmd_seen && cmd == {gtl_pkg::GRP_LISTEN, gtl_pkg::ADDR_NONE})
      listen_r <= 1'b0;
  end

  // any other talk address, the untalk code included, clears our talker role
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      talk_r <= 1'b0;
    else if (ifc_on)
      talk_r <= 1'b0;
    else if (cmd_seen && cmd == {gtl_pkg::GRP_TALK, MY_ADDR})
      talk_r <= 1'b1;
    else if (cmd_seen && cmd[gtl_pkg::GRP_HI:gtl_pkg::GRP_LO] == gtl_pkg::GRP_TALK)
      talk_r <= 1'b0;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      remote_r <= 1'b0;
    else if (!ren_on)
      remote_r <= 1'b0;
    else if (cmd_seen && cmd == {gtl_pkg::GRP_LISTEN, MY_ADDR})
      remote_r <= 1'b1;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      srq_r <= 1'b0;
    else
      srq_r <= SRQ_REQ;
  end

  // talker stops at once when ATN returns; a half-sent byte is dropped
  assign src_en = talk_r && !atn_on && !ifc_on;

  gtl_hs_src u_src (
    .clk(CLK),
    .rst_n(RESETN),
    .en(src_en),
    .valid(TX_VALID),
    .data(TX_DATA),
    .eoi(TX_EOI),
    .ready(TX_READY),
    .done(TX_DONE),
    .line(BUS.line),
    .dio_drv(src_dio),
    .dav_drv(src_dav),
    .eoi_drv(src_eoi)
  );

  // ATN, IFC and REN are never driven from this end
  always_comb
  begin
    drv = '0;
    drv[gtl_pkg::DW-1:0] = src_dio;
    drv[gtl_pkg::L_DAV] = src_dav;
    drv[gtl_pkg::L_EOI] = src_eoi;
    drv[gtl_pkg::L_SRQ] = srq_r;
    // released while off so another listener alone decides the wired lines
    drv[gtl_pkg::L_NRFD] = acc_r == gtl_pkg::ACC_TAKEN || (acc_r == gtl_pkg::ACC_WAIT && !acc_rdy);
    drv[gtl_pkg::L_NDAC] = acc_r == gtl_pkg::ACC_WAIT;
  end

  assign BUS.dev_o = '0;
  assign BUS.dev_oe = drv;

  assign RX_VALID = got_r && !rx_atn_r;
  assign RX_DATA = rx_data_r;
  assign RX_EOI = rx_eoi_r;
  assign TALK = talk_r;
  assign LISTEN = listen_r;
  assign REMOTE = remote_r;
endmodule
`default_nettype wire

// ### core/gtl_pkg.sv
// shared constants and types for the talker/listener port and its controller
`default_nettype none
package gtl_pkg;
  localparam int DW = 8;
  localparam int NLINES = 16;
  // bit index of each bus line in the line vector; data lines are 0..7
  localparam int L_DAV = 8;
  localparam int L_NRFD = 9;
  localparam int L_NDAC = 10;
  localparam int L_EOI = 11;
  localparam int L_SRQ = 12;
  localparam int L_ATN = 13;
  localparam int L_IFC = 14;
  localparam int L_REN = 15;
  localparam int CLK_NS = 100;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int IFC_NS = 100000;
  localparam int IFC_CYC = (IFC_NS + CLK_NS - 1) / CLK_NS;
  // command byte layout: bits 6:5 group, bits 4:0 address
  localparam int GRP_HI = 6;
  localparam int GRP_LO = 5;
  localparam int AW = 5;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [4:0] ADDR_NONE = 5'h1F;
  typedef enum logic [1:0] {SRC_IDLE = 2'b00, SRC_SETTLE = 2'b01, SRC_DAV = 2'b10} gtl_src_t;
  typedef enum logic [1:0] {ACC_OFF = 2'b00, ACC_WAIT = 2'b01, ACC_TAKEN = 2'b10} gtl_acc_t;
endpackage
`default_nettype wire

// ### core/gtl_bus_if.sv
// the sixteen shared open-drain bus lines between the port and the controller
`default_nettype none
interface gtl_bus_if;
  logic [gtl_pkg::NLINES-1:0] dev_o;
  logic [gtl_pkg::NLINES-1:0] dev_oe;
  logic [gtl_pkg::NLINES-1:0] ctl_o;
  logic [gtl_pkg::NLINES-1:0] ctl_oe;
  logic [gtl_pkg::NLINES-1:0] line;
  // wired-AND: a line is low while any party drives it low
  assign line = ~((dev_oe & ~dev_o) | (ctl_oe & ~ctl_o));
  modport dev (input line, output dev_o, output dev_oe);
  modport ctl (input line, output ctl_o, output ctl_oe);
endinterface
`default_nettype wire

// ### core/gtl_hs_src.sv
// source half of the three-wire byte handshake, shared by both ends
`default_nettype none
module gtl_hs_src #(
  parameter int SETTLE = gtl_pkg::SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic valid,
  input wire logic [gtl_pkg::DW-1:0] data,
  input wire logic eoi,
  output logic ready,
  output logic done,
  input wire logic [gtl_pkg::NLINES-1:0] line,
  output logic [gtl_pkg::DW-1:0] dio_drv,
  output logic dav_drv,
  output logic eoi_drv
);
  localparam int CW = $clog2(SETTLE + 1);
  gtl_pkg::gtl_src_t st_r;
  logic [gtl_pkg::DW-1:0] data_r;
  logic eoi_r;
  logic [CW-1:0] cnt_r;
  logic done_r;
  logic nrfd_hi;
  logic ndac_hi;
  logic start;

  assign nrfd_hi = line[gtl_pkg::L_NRFD];
  assign ndac_hi = line[gtl_pkg::L_NDAC];
  assign start = en && valid && st_r == gtl_pkg::SRC_IDLE;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= gtl_pkg::SRC_IDLE;
    else if (!en)
      st_r <= gtl_pkg::SRC_IDLE;
    else
      unique case (st_r)
        gtl_pkg::SRC_IDLE:
          if (valid)
            st_r <= gtl_pkg::SRC_SETTLE;
        gtl_pkg::SRC_SETTLE:
          if (cnt_r == '0 && nrfd_hi && !ndac_hi)
            st_r <= gtl_pkg::SRC_DAV;
        gtl_pkg::SRC_DAV:
          if (ndac_hi)
            st_r <= gtl_pkg::SRC_IDLE;
        default:
          st_r <= gtl_pkg::SRC_IDLE;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_r <= '0;
      eoi_r <= 1'b0;
      cnt_r <= '0;
    end
    else if (start)
    begin
      data_r <= data;
      eoi_r <= eoi;
      cnt_r <= CW'(SETTLE - 1);
    end
    else if (st_r == gtl_pkg::SRC_SETTLE && cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      done_r <= 1'b0;
    else
      done_r <= en && st_r == gtl_pkg::SRC_DAV && ndac_hi;
  end

  assign ready = en && st_r == gtl_pkg::SRC_IDLE;
  assign done = done_r;
  // data held on the lines from presentation until DAV is withdrawn
  assign dio_drv = (st_r != gtl_pkg::SRC_IDLE) ? data_r : '0;
  assign dav_drv = st_r == gtl_pkg::SRC_DAV;
  assign eoi_drv = st_r != gtl_pkg::SRC_IDLE && eoi_r;
endmodule
`default_nettype wire

// ### core/gtl_ctl_port.sv
// system controller end of the bus: commands, data and listening
`default_nettype none
module gtl_ctl_port #(
  parameter int IFC_LEN = gtl_pkg::IFC_CYC
) (
  input wire logic CLK,
  input wire logic RESETN,
  gtl_bus_if.ctl BUS,
  input wire logic IFC_REQ,
  output logic IFC_BUSY,
  input wire logic REN_SET,
  input wire logic ATN_SET,
  output logic ATN_STATE,
  input wire logic TX_VALID,
  input wire logic [gtl_pkg::DW-1:0] TX_DATA,
  input wire logic TX_EOI,
  output logic TX_READY,
  output logic TX_DONE,
  input wire logic LISTEN_EN,
  input wire logic RX_READY,
  output logic RX_VALID,
  output logic [gtl_pkg::DW-1:0] RX_DATA,
  output logic RX_EOI,
  output logic SRQ_SEEN
);
  localparam int IW = $clog2(IFC_LEN + 1);
  logic [IW-1:0] ifc_cnt_r;
  logic ifc_on;
  logic atn_r;
  logic ren_r;
  logic src_ready;
  logic src_ok;
  logic [gtl_pkg::DW-1:0] src_dio;
  logic src_dav;
  logic src_eoi;
  gtl_pkg::gtl_acc_t acc_r;
  logic acc_en;
  logic dav_on;
  logic take;
  logic got_r;
  logic [gtl_pkg::DW-1:0] rx_data_r;
  logic rx_eoi_r;
  logic [gtl_pkg::NLINES-1:0] drv;

  assign ifc_on = ifc_cnt_r != '0;
  assign dav_on = ~BUS.line[gtl_pkg::L_DAV];

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      ifc_cnt_r <= '0;
    else if (IFC_REQ && !ifc_on)
      ifc_cnt_r <= IW'(IFC_LEN);
    else if (ifc_on)
      ifc_cnt_r <= ifc_cnt_r - 1'b1;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      ren_r <= 1'b0;
    else
      ren_r <= REN_SET;
  end

  // ATN only changes while this end's source is idle, so none of its own bytes is cut in half
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      atn_r <= 1'b0;
    else if (src_ready)
      atn_r <= ATN_SET;
  end

  assign src_ok = atn_r == ATN_SET;
  assign TX_READY = src_ready && src_ok;

  gtl_hs_src u_src (
    .clk(CLK),
    .rst_n(RESETN),
    .en(!ifc_on),
    .valid(TX_VALID && src_ok),
    .data(TX_DATA),
    .eoi(TX_EOI),
    .ready(src_ready),
    .done(TX_DONE),
    .line(BUS.line),
    .dio_drv(src_dio),
    .dav_drv(src_dav),
    .eoi_drv(src_eoi)
  );

  assign acc_en = LISTEN_EN && !atn_r && !ifc_on;
  assign take = acc_r == gtl_pkg::ACC_WAIT && acc_en && RX_READY && dav_on;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      acc_r <= gtl_pkg::ACC_OFF;
    else if (!acc_en)
      acc_r <= gtl_pkg::ACC_OFF;
    else
      unique case (acc_r)
        gtl_pkg::ACC_OFF:
          acc_r <= gtl_pkg::ACC_WAIT;
        gtl_pkg::ACC_WAIT:
          if (take)
            acc_r <= gtl_pkg::ACC_TAKEN;
        gtl_pkg::ACC_TAKEN:
          if (!dav_on)
            acc_r <= gtl_pkg::ACC_WAIT;
        default:
          acc_r <= gtl_pkg::ACC_OFF;
      endcase
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rx_data_r <= '0;
      rx_eoi_r <= 1'b0;
      got_r <= 1'b0;
    end
    else
    begin
      got_r <= take;
      if (take)
      begin
        rx_data_r <= ~BUS.line[gtl_pkg::DW-1:0];
        rx_eoi_r <= ~BUS.line[gtl_pkg::L_EOI];
      end
    end
  end

  always_comb
  begin
    drv = '0;
    drv[gtl_pkg::DW-1:0] = src_dio;
    drv[gtl_pkg::L_DAV] = src_dav;
    // EOI together with ATN means identify, so it is kept off for commands
    drv[gtl_pkg::L_EOI] = src_eoi && !atn_r;
    drv[gtl_pkg::L_ATN] = atn_r;
    drv[gtl_pkg::L_IFC] = ifc_on;
    drv[gtl_pkg::L_REN] = ren_r;
    drv[gtl_pkg::L_NRFD] = acc_r == gtl_pkg::ACC_TAKEN || (acc_r == gtl_pkg::ACC_WAIT && !RX_READY);
    drv[gtl_pkg::L_NDAC] = acc_r == gtl_pkg::ACC_WAIT;
  end

  assign BUS.ctl_o = '0;
  assign BUS.ctl_oe = drv;

  assign IFC_BUSY = ifc_on;
  assign ATN_STATE = atn_r;
  assign RX_VALID = got_r;
  assign RX_DATA = rx_data_r;
  assign RX_EOI = rx_eoi_r;
  assign SRQ_SEEN = ~BUS.line[gtl_pkg::L_SRQ];
endmodule
`default_nettype wire

// ### sim/gtl_monitor.sv
// bus-level checker for the byte handshake between controller and instrument
`default_nettype none
module gtl_monitor #(
  parameter int SETTLE = gtl_pkg::SETTLE_CYC
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [gtl_pkg::NLINES-1:0] dev_o,
  input wire logic [gtl_pkg::NLINES-1:0] dev_oe,
  input wire logic [gtl_pkg::NLINES-1:0] ctl_o,
  input wire logic [gtl_pkg::NLINES-1:0] ctl_oe,
  input wire logic [gtl_pkg::NLINES-1:0] line
);
  logic dav;
  logic nrfd;
  logic ndac;
  logic [7:0] hi_cnt_r;
  assign dav = line[gtl_pkg::L_DAV];
  assign nrfd = line[gtl_pkg::L_NRFD];
  assign ndac = line[gtl_pkg::L_NDAC];
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // saturates so long idle spans cannot wrap back under the settle figure
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      hi_cnt_r <= 8'h00;
    else if (!dav)
      hi_cnt_r <= 8'h00;
    else if (hi_cnt_r != 8'hFF)
      hi_cnt_r <= hi_cnt_r + 8'h01;
  end
  a_dav_needs_ready: assert property ($fell(dav) |-> $past(nrfd) && !$past(ndac))
    else $error("dav asserted without nrfd released and ndac held");
  a_ndac_at_dav: assert property ($fell(dav) |-> !ndac)
    else $error("ndac not asserted when dav came");
  a_settle_before_dav: assert property ($fell(dav) |-> int'(hi_cnt_r) >= SETTLE)
    else $error("dav asserted before data settled");
  a_data_held: assert property (!dav |=> dav || ($stable(line[7:0]) && $stable(line[gtl_pkg::L_EOI])))
    else $error("data or eoi changed under dav");
  a_nrfd_on_take: assert property (!dav && ndac |-> !nrfd)
    else $error("nrfd released after byte taken");
  a_dav_release: assert property (!dav && ndac |-> ##[1:2] dav)
    else $error("dav not released after ndac release");
  a_ndac_back: assert property ($rose(dav) && ndac |-> ##[1:2] !ndac)
    else $error("ndac not reasserted after dav release");
  a_never_ctl: assert property (!(dev_oe[gtl_pkg::L_ATN] || dev_oe[gtl_pkg::L_IFC] || dev_oe[gtl_pkg::L_REN]))
    else $error("instrument drove a controller line");
  a_ifc_abort: assert property (!line[gtl_pkg::L_IFC] |=> !dev_oe[gtl_pkg::L_DAV] && dev_oe[7:0] == 8'h00)
    else $error("instrument kept talking under ifc");
  a_open_drain: assert property ((dev_o | ctl_o) == '0)
    else $error("a party drove a line high");
  c_command: cover property ($fell(dav) && !line[gtl_pkg::L_ATN]);
  c_data: cover property ($fell(dav) && line[gtl_pkg::L_ATN]);
  c_end: cover property ($fell(dav) && !line[gtl_pkg::L_EOI]);
  c_clear: cover property ($fell(line[gtl_pkg::L_IFC]));
endmodule
`default_nettype wire

// ### sim/gtl_talker_listener_port_tb.sv
// self-checking bench: controller and instrument ends joined on one bus
`default_nettype none
module gtl_talker_listener_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic srq_req = 1'b0;
  logic d_tx_valid = 1'b0;
  logic d_tx_eoi = 1'b0;
  logic d_rx_ready = 1'b0;
  logic ifc_req = 1'b0;
  logic ren_set = 1'b0;
  logic atn_set = 1'b0;
  logic c_tx_valid = 1'b0;
  logic c_tx_eoi = 1'b0;
  logic c_listen_en = 1'b0;
  logic c_rx_ready = 1'b0;
  logic [7:0] d_tx_data = 8'h00;
  logic [7:0] c_tx_data = 8'h00;
  logic [7:0] d_rx_data;
  logic [7:0] c_rx_data;
  logic d_tx_ready, d_tx_done, d_rx_valid, d_rx_eoi, talk, listen, remote;
  logic ifc_busy, atn_state, c_tx_ready, c_tx_done, c_rx_valid, c_rx_eoi, srq_seen;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [8:0] d_q[$];
  logic [8:0] c_q[$];
  gtl_bus_if bus();
  always #50 clk = ~clk;
  gtl_dev_port i_gtl_dev_port (.CLK(clk), .RESETN(rst_n), .BUS(bus.dev), .MY_ADDR(5'h05), .SRQ_REQ(srq_req),
    .TX_VALID(d_tx_valid), .TX_DATA(d_tx_data), .TX_EOI(d_tx_eoi), .TX_READY(d_tx_ready), .TX_DONE(d_tx_done),
    .RX_READY(d_rx_ready), .RX_VALID(d_rx_valid), .RX_DATA(d_rx_data), .RX_EOI(d_rx_eoi), .TALK(talk),
    .LISTEN(listen), .REMOTE(remote));
  gtl_ctl_port #(.IFC_LEN(4)) i_gtl_ctl_port (.CLK(clk), .RESETN(rst_n), .BUS(bus.ctl), .IFC_REQ(ifc_req),
    .IFC_BUSY(ifc_busy), .REN_SET(ren_set), .ATN_SET(atn_set), .ATN_STATE(atn_state), .TX_VALID(c_tx_valid),
    .TX_DATA(c_tx_data), .TX_EOI(c_tx_eoi), .TX_READY(c_tx_ready), .TX_DONE(c_tx_done), .LISTEN_EN(c_listen_en),
    .RX_READY(c_rx_ready), .RX_VALID(c_rx_valid), .RX_DATA(c_rx_data), .RX_EOI(c_rx_eoi), .SRQ_SEEN(srq_seen));
  gtl_monitor u_mon (.CLK(clk), .RESETN(rst_n), .dev_o(bus.dev_o), .dev_oe(bus.dev_oe), .ctl_o(bus.ctl_o),
    .ctl_oe(bus.ctl_oe), .line(bus.line));
  task automatic tally_and_finish();
  begin
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
  begin
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  end
  endtask
  // pops one received byte with its end mark; an empty queue yields unknowns
  task automatic chk_rx(input logic side, input logic [8:0] exp);
    logic [8:0] got;
  begin
    got = 9'bx;
    if (side && d_q.size() > 0)
      got = d_q.pop_front();
    if (!side && c_q.size() > 0)
      got = c_q.pop_front();
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: byte %h want %h", $time, got, exp);
    end
  end
  endtask
  // side 1 = instrument sends, 0 = controller sends
  task automatic xfer(input logic side, input logic atn, input logic [7:0] d, input logic eoi);
    int n;
    logic seen;
  begin
    seen = 1'b0;
    n = 0;
    @(posedge clk);
    atn_set <= atn;
    d_tx_valid <= side;
    c_tx_valid <= !side;
    d_tx_data <= d;
    c_tx_data <= d;
    d_tx_eoi <= eoi;
    c_tx_eoi <= eoi;
    @(negedge clk);
    while ((side ? d_tx_ready : c_tx_ready) !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    d_tx_valid <= 1'b0;
    c_tx_valid <= 1'b0;
    while ((side ? d_tx_done : c_tx_done) !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
      if (!seen && bus.line[gtl_pkg::L_DAV] === 1'b0)
      begin
        seen = 1'b1;
        chk_flag(bus.line[7:0] === ~d, 1'b1);
        chk_flag(bus.line[gtl_pkg::L_EOI], ~(eoi & ~atn));
        chk_flag(bus.line[gtl_pkg::L_ATN], ~atn);
      end
    end
    chk_flag(n < 300, 1'b1);
    repeat (3) @(negedge clk);
  end
  endtask
  always @(negedge clk)
  begin
    if (d_rx_valid === 1'b1)
      d_q.push_back({d_rx_eoi, d_rx_data});
    if (c_rx_valid === 1'b1)
      c_q.push_back({c_rx_eoi, c_rx_data});
  end
  // whole run needs about 400 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_flag(bus.line === 16'hFFFF, 1'b1);
    @(posedge clk);
    ren_set <= 1'b1;
    xfer(1'b0, 1'b1, 8'h25, 1'b0);
    chk_flag(listen, 1'b1);
    chk_flag(remote, 1'b1);
    chk_flag(atn_state, 1'b1);
    chk_flag(d_q.size() == 0, 1'b1);
    fork
      xfer(1'b0, 1'b0, 8'hA5, 1'b0);
      begin
        repeat (40) @(negedge clk);
        chk_flag(bus.line[gtl_pkg::L_DAV], 1'b1);
        chk_flag(bus.line[gtl_pkg::L_NRFD], 1'b0);
        @(posedge clk);
        d_rx_ready <= 1'b1;
      end
    join
    chk_flag(atn_state, 1'b0);
    xfer(1'b0, 1'b0, 8'h3C, 1'b1);
    chk_rx(1'b1, 9'h0A5);
    chk_rx(1'b1, 9'h13C);
    xfer(1'b0, 1'b1, 8'h3F, 1'b0);
    chk_flag(listen, 1'b0);
    xfer(1'b0, 1'b1, 8'h45, 1'b0);
    chk_flag(talk, 1'b1);
    @(posedge clk);
    c_listen_en <= 1'b1;
    c_rx_ready <= 1'b1;
    xfer(1'b1, 1'b0, 8'h81, 1'b0);
    xfer(1'b1, 1'b0, 8'h7E, 1'b1);
    chk_rx(1'b0, 9'h081);
    chk_rx(1'b0, 9'h17E);
    @(posedge clk);
    c_listen_en <= 1'b0;
    xfer(1'b0, 1'b1, 8'h46, 1'b0);
    chk_flag(talk, 1'b0);
    xfer(1'b0, 1'b1, 8'h25, 1'b0);
    xfer(1'b0, 1'b1, 8'h45, 1'b0);
    @(posedge clk);
    ifc_req <= 1'b1;
    @(posedge clk);
    ifc_req <= 1'b0;
    @(negedge clk);
    chk_flag(ifc_busy, 1'b1);
    repeat (7) @(negedge clk);
    chk_flag(ifc_busy, 1'b0);
    chk_flag(talk, 1'b0);
    chk_flag(listen, 1'b0);
    chk_flag(remote, 1'b1);
    @(posedge clk);
    ren_set <= 1'b0;
    repeat (4) @(negedge clk);
    chk_flag(remote, 1'b0);
    xfer(1'b0, 1'b1, 8'h25, 1'b0);
    chk_flag(listen, 1'b1);
    chk_flag(remote, 1'b0);
    // two listeners on one byte: the slow instrument alone must hold the wired line
    @(posedge clk);
    d_rx_ready <= 1'b0;
    c_listen_en <= 1'b1;
    fork
      xfer(1'b0, 1'b0, 8'h5A, 1'b0);
      begin
        repeat (40) @(negedge clk);
        chk_flag(bus.line[gtl_pkg::L_NRFD], 1'b0);
        chk_flag(bus.ctl_oe[gtl_pkg::L_NRFD], 1'b0);
        @(posedge clk);
        d_rx_ready <= 1'b1;
      end
    join
    chk_rx(1'b1, 9'h05A);
    chk_rx(1'b0, 9'h05A);
    @(posedge clk);
    c_listen_en <= 1'b0;
    @(posedge clk);
    srq_req <= 1'b1;
    repeat (3) @(negedge clk);
    chk_flag(srq_seen, 1'b1);
    @(posedge clk);
    srq_req <= 1'b0;
    repeat (3) @(negedge clk);
    chk_flag(srq_seen, 1'b0);
    chk_flag(d_q.size() == 0 && c_q.size() == 0, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
